// ---- core/ocf_axi_slave.sv ----
// Purpose: AXI4-Lite slave front end producing single-cycle write and read strobes
// Assumes: One write and one read at a time
// Notes: Write answer two cycles after both channels taken, read answer two cycles after the address
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module ocf_axi_slave
    import ocf_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [OCF_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic bvalid,
    output logic [1:0] bresp,
    input wire logic bready,
    input wire logic [OCF_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic wrStb,
    output ocf_wreq_t wrReq,
    input wire logic wrOk,
    output logic rdStb,
    output logic [OCF_ADDR_W-1:0] rdAddr,
    input wire logic [31:0] rdData,
    input wire logic rdOk
);
    ocf_wstate_t wst_q, wst_d;
    logic awHave_q, awHave_d, wHave_q, wHave_d;
    ocf_wreq_t req_q, req_d;
    logic stb_q, stb_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic arPend_q, arPend_d;

    // ----------------------------------------
    // Write path: address and data in either order
    // ----------------------------------------
    always_comb
    begin
        wst_d = wst_q;
        awHave_d = awHave_q;
        wHave_d = wHave_q;
        req_d = req_q;
        stb_d = 1'b0;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (wst_q == OCF_W_IDLE)
        begin
            if (awvalid && !awHave_q)
            begin
                awHave_d = 1'b1;
                req_d.addr = awaddr;
            end
            if (wvalid && !wHave_q)
            begin
                wHave_d = 1'b1;
                req_d.data = wdata;
                req_d.strb = wstrb;
            end
            if (awHave_d && wHave_d)
            begin
                stb_d = 1'b1;
                wst_d = OCF_W_RESP;
            end
        end
        else
        begin
            if (stb_q)
            begin
                bvalid_d = 1'b1;
                bresp_d = wrOk ? OCF_RESP_OKAY : OCF_RESP_SLVERR;
            end
            else if (bvalid_q && bready)
            begin
                bvalid_d = 1'b0;
                awHave_d = 1'b0;
                wHave_d = 1'b0;
                wst_d = OCF_W_IDLE;
            end
        end
    end

    // ----------------------------------------
    // Read path: data captured the cycle after the address
    // ----------------------------------------
    always_comb
    begin
        arPend_d = 1'b0;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arvalid && !rvalid_q && !arPend_q)
            arPend_d = 1'b1;
        if (arPend_q)
        begin
            rvalid_d = 1'b1;
            rdata_d = rdData;
            rresp_d = rdOk ? OCF_RESP_OKAY : OCF_RESP_SLVERR;
        end
        else if (rvalid_q && rready)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wst_q <= OCF_W_IDLE;
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            req_q <= '0;
            stb_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= OCF_RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= OCF_RESP_OKAY;
            arPend_q <= 1'b0;
            rdAddr <= '0;
        end
        else if (en)
        begin
            wst_q <= wst_d;
            awHave_q <= awHave_d;
            wHave_q <= wHave_d;
            req_q <= req_d;
            stb_q <= stb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            arPend_q <= arPend_d;
            if (arvalid && !rvalid_q && !arPend_q)
                rdAddr <= araddr;
        end
    end

    // Ready only while idle, so a held item is taken exactly once
    assign awready = en && (wst_q == OCF_W_IDLE) && !awHave_q;
    assign wready = en && (wst_q == OCF_W_IDLE) && !wHave_q;
    assign arready = en && !rvalid_q && !arPend_q;
    assign wrStb = stb_q;
    assign wrReq = req_q;
    assign rdStb = arPend_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
endmodule
`default_nettype wire

// ---- core/ocf_pkg.sv ----
// Purpose: Shared constants and types for the five-channel output-compare flag block
// Assumes: AXI4-Lite register access with 32-bit data
// Notes: Offsets are byte addresses of aligned words
package ocf_pkg;
    localparam int OCF_CHANNELS = 5;
    localparam int OCF_CMP_W = 16;
    localparam int OCF_ADDR_W = 8;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OCF_OFF_FLAG = 8'h00;
    localparam logic [7:0] OCF_OFF_IRQEN = 8'h04;
    localparam logic [7:0] OCF_OFF_COUNT = 8'h08;
    localparam logic [7:0] OCF_OFF_CMP_BASE = 8'h10;
    localparam logic [7:0] OCF_OFF_CMP_END = 8'h24;
    localparam logic [15:0] OCF_CMP_RESET = 16'hffff;
    localparam logic [1:0] OCF_RESP_OKAY = 2'h0;
    localparam logic [1:0] OCF_RESP_SLVERR = 2'h2;
    localparam logic [3:0] OCF_STRB_LO = 4'h1;
    localparam logic [3:0] OCF_STRB_HI = 4'h2;

    typedef struct packed {
        logic [OCF_ADDR_W-1:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } ocf_wreq_t;

    typedef enum logic [1:0] {
        OCF_W_IDLE = 2'b00,
        OCF_W_RESP = 2'b01
    } ocf_wstate_t;
endpackage

// ---- core/ocf_channel.sv ----
// Purpose: One compare channel: compare value, inhibit and sticky match flag
// Assumes: Count is synchronous to clk
// Notes: High-byte write blocks comparison in the write cycle and the cycle after
`timescale 1ns/100ps
`default_nettype none
module ocf_channel
    import ocf_pkg::*;
#(
    parameter int W = OCF_CMP_W
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [W-1:0] count,
    input wire logic wrLo,
    input wire logic wrHi,
    input wire logic [W-1:0] wrData,
    input wire logic flagClr,
    output logic [W-1:0] compareValue,
    output logic matchFlag
);
    logic [W-1:0] cmp_q, cmp_d;
    logic inhibit_q, inhibit_d;
    logic flag_q, flag_d;
    logic hit;

    always_comb
    begin
        cmp_d = cmp_q;
        if (wrLo)
            cmp_d[7:0] = wrData[7:0];
        if (wrHi)
            cmp_d[W-1:8] = wrData[W-1:8];
        inhibit_d = wrHi;
        hit = (count == cmp_q) && !inhibit_q && !wrHi;
        flag_d = flag_q;
        if (flagClr)
            flag_d = 1'b0;
        if (hit)
            flag_d = 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_q <= OCF_CMP_RESET;
            inhibit_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else if (en)
        begin
            cmp_q <= cmp_d;
            inhibit_q <= inhibit_d;
            flag_q <= flag_d;
        end
    end

    assign compareValue = cmp_q;
    assign matchFlag = flag_q;
endmodule
`default_nettype wire

// ---- core/ocf_top.sv ----
// Purpose: Five output-compare channels with match flags, enables and interrupt
// Assumes: Free-running count arrives from logic on the same clock
// Notes: Flag register is write-one-to-clear; irq is a registered level
`timescale 1ns/100ps
`default_nettype none
// Operation
// - A configured channel acts on every match, not only the first.
// - A channel's match flag is set whenever its compare value equals the count, except while a high-byte compare write blocks comparison.
// - Writing a one to a flag bit clears that channel's flag.
// - The interrupt enable does not change how the flag sets or clears.
// - With enable at zero the channel raises no interrupt request.
// - With enable at one a set flag raises the interrupt request.
// - There are five independent channels, each with its own flag and enable.
// - A high-byte compare write blocks that channel's comparison in the write cycle and the cycle after.
// - Compare values are 16 bits, compared in full against the 16-bit count.
module ocf_top
    import ocf_pkg::*;
#(
    parameter int N = OCF_CHANNELS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic [OCF_CMP_W-1:0] freeRunningCount,
    input wire logic [OCF_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic bvalid,
    output logic [1:0] bresp,
    input wire logic bready,
    input wire logic [OCF_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic compareIrq
);
    logic wrStb, rdStb, wrOk, rdOk;
    ocf_wreq_t wrReq;
    logic [OCF_ADDR_W-1:0] rdAddr;
    logic [31:0] rdData;
    logic [N-1:0] matchFlag, flagClr, wrLo, wrHi;
    logic [OCF_CMP_W-1:0] cmpVal [N];
    logic [N-1:0] irqEn_q, irqEn_d;
    logic irq_q, irq_d;

    ocf_axi_slave u_bus (
        .clk(clk), .rst(rst), .en(en),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bvalid(bvalid), .bresp(bresp), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .wrStb(wrStb), .wrReq(wrReq), .wrOk(wrOk),
        .rdStb(rdStb), .rdAddr(rdAddr), .rdData(rdData), .rdOk(rdOk)
    );

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    always_comb
    begin
        flagClr = '0;
        wrLo = '0;
        wrHi = '0;
        irqEn_d = irqEn_q;
        wrOk = 1'b1;
        if (wrStb && wrReq.addr == OCF_OFF_FLAG)
            flagClr = wrReq.strb[0] ? wrReq.data[N-1:0] : '0;
        else if (wrStb && wrReq.addr == OCF_OFF_IRQEN)
        begin
            if (wrReq.strb[0])
                irqEn_d = wrReq.data[N-1:0];
        end
        else if (wrStb && wrReq.addr == OCF_OFF_COUNT)
            wrOk = 1'b1;
        else if (wrStb && wrReq.addr >= OCF_OFF_CMP_BASE && wrReq.addr < OCF_OFF_CMP_END
                 && wrReq.addr[1:0] == 2'h0)
        begin
            for (int i = 0; i < N; i++)
                if (wrReq.addr == OCF_OFF_CMP_BASE + OCF_ADDR_W'(4 * i))
                begin
                    wrLo[i] = |(wrReq.strb & OCF_STRB_LO);
                    wrHi[i] = |(wrReq.strb & OCF_STRB_HI);
                end
        end
        else if (wrStb)
            wrOk = 1'b0;
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    for (genvar g = 0; g < N; g++)
    begin : gCh
        // Enable is not wired in: flags behave the same polled or interrupt driven
        ocf_channel #(.W(OCF_CMP_W)) u_ch (
            .clk(clk), .rst(rst), .en(en),
            .count(freeRunningCount),
            .wrLo(wrLo[g]), .wrHi(wrHi[g]),
            .wrData(wrReq.data[OCF_CMP_W-1:0]),
            .flagClr(flagClr[g]),
            .compareValue(cmpVal[g]),
            .matchFlag(matchFlag[g])
        );
    end

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    always_comb
    begin
        rdData = '0;
        rdOk = 1'b1;
        if (rdAddr == OCF_OFF_FLAG)
            rdData[N-1:0] = matchFlag;
        else if (rdAddr == OCF_OFF_IRQEN)
            rdData[N-1:0] = irqEn_q;
        else if (rdAddr == OCF_OFF_COUNT)
            rdData[OCF_CMP_W-1:0] = freeRunningCount;
        else if (rdAddr >= OCF_OFF_CMP_BASE && rdAddr < OCF_OFF_CMP_END && rdAddr[1:0] == 2'h0)
        begin
            for (int i = 0; i < N; i++)
                if (rdAddr == OCF_OFF_CMP_BASE + OCF_ADDR_W'(4 * i))
                    rdData[OCF_CMP_W-1:0] = cmpVal[i];
        end
        else
            rdOk = 1'b0;
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    always_comb
    begin
        irq_d = |(matchFlag & irqEn_q);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irqEn_q <= '0;
            irq_q <= 1'b0;
        end
        else if (en)
        begin
            irqEn_q <= irqEn_d;
            irq_q <= irq_d;
        end
    end

    assign compareIrq = irq_q;
endmodule
`default_nettype wire

// ---- tb/ocf_monitor.sv ----
// Purpose: Port checks for ocf_top
// Assumes: One clock, rst async high
// Notes: Flags are internal, so irq is tied to bus writes
`timescale 1ns/100ps
`default_nettype none
module ocf_monitor
    import ocf_pkg::*;
#(
    parameter int N = OCF_CHANNELS
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic [1:0] bresp,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic compareIrq
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    writeHold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    readHold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    // A stall of en aborts the latency checks, since it freezes the slave
    writeLatency_a: assert property (disable iff (rst || !en) awvalid && awready && wvalid && wready |-> ##[2:3] bvalid)
        else $error("write answer late");
    readLatency_a: assert property (disable iff (rst || !en) arvalid && arready |-> ##[2:3] rvalid)
        else $error("read answer late");
    stallReady_a: assert property (!en |-> !awready && !wready && !arready)
        else $error("ready while stalled");
    busyReady_a: assert property (bvalid |-> !awready && !wready)
        else $error("ready while answer pending");
    irqFrozen_a: assert property (!en |=> $stable(compareIrq))
        else $error("irq moved while stalled");
    irqDrop_a: assert property ($fell(compareIrq) |-> $past(bvalid) || $past(bvalid, 2) || $past(bvalid, 3))
        else $error("irq fell without a write");
endmodule
bind ocf_top ocf_monitor #(.N(N)) i_ocf_monitor (.clk(clk), .rst(rst), .en(en), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
    .compareIrq(compareIrq));
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for ocf_top
// Assumes: Count held by the bench, odd compare values
// Notes: Idle count of zero never matches an odd compare value
`timescale 1ns/100ps
`default_nettype none
module tb
    import ocf_pkg::*;
;
    logic clk, rst, en, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, compareIrq;
    logic [15:0] cnt;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [4:0] flagM, enM;
    logic [15:0] cmpM [5];
    logic [15:0] nv;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 68;
    ocf_top i_ocf_top (.clk(clk), .rst(rst), .en(en), .freeRunningCount(cnt), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bvalid(bvalid), .bresp(bresp), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .compareIrq(compareIrq));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (!(awvalid === 1'b0 || awready === 1'b1) || !(wvalid === 1'b0 || wready === 1'b1));
        while (bvalid !== 1'b1)
            @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    // Reference model: every channel other than skip whose compare value equals the count sets its flag
    task automatic model(input logic [15:0] v, input int skip);
        for (int j = 0; j < 5; j++)
            if (cmpM[j] == v && j != skip)
                flagM[j] = 1'b1;
    endtask
    task automatic pulse(input logic [15:0] v);
        @(posedge clk) cnt <= v;
        model(v, -1);
        @(posedge clk) cnt <= 16'h0000;
        repeat (3) @(posedge clk);
    endtask
    task automatic checkFlags();
        rd(OCF_OFF_FLAG);
        check(d, {27'h0, flagM});
    endtask
    task automatic checkIrq();
        repeat (3) @(posedge clk);
        check({31'h0, compareIrq}, {31'h0, |(flagM & enM)});
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {rst, en, cnt, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata, wstrb} = '0;
        rst = 1'b1;
        en = 1'b1;
        flagM = '0;
        enM = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        checkFlags();
        checkIrq();
        for (int i = 0; i < 5; i++)
        begin
            rd(OCF_OFF_CMP_BASE + 8'(4 * i));
            check(d, {16'h0, OCF_CMP_RESET});
            cmpM[i] = 16'($random(seed)) | 16'h0001;
            wr(OCF_OFF_CMP_BASE + 8'(4 * i), {16'h0, cmpM[i]});
            rd(OCF_OFF_CMP_BASE + 8'(4 * i));
            check(d, {16'h0, cmpM[i]});
        end
        for (int i = 0; i < 5; i++)
        begin
            pulse(cmpM[i] ^ 16'h8000);
            checkFlags();
            pulse(cmpM[i]);
            flagM[i] = 1'b1;
            checkFlags();
            checkIrq();
        end
        wr(OCF_OFF_FLAG, 32'h0);
        checkFlags();
        wr(OCF_OFF_FLAG, 32'h0a);
        flagM &= ~5'h0a;
        checkFlags();
        pulse(cmpM[1]);
        flagM[1] = 1'b1;
        checkFlags();
        for (int i = 0; i < 6; i++)
        begin
            enM = (i == 5) ? 5'h1f : 5'(1 << i);
            wr(OCF_OFF_IRQEN, {27'h0, enM});
            checkIrq();
        end
        @(posedge clk) en <= 1'b0;
        repeat (4) @(posedge clk);
        en <= 1'b1;
        checkIrq();
        wr(OCF_OFF_FLAG, 32'h1f);
        flagM = '0;
        checkIrq();
        // Match lands in the very cycle of the clearing strobe, so only set-wins keeps the flag
        fork
            wr(OCF_OFF_FLAG, 32'h04);
            begin
                repeat (2) @(posedge clk);
                cnt <= cmpM[2];
                model(cmpM[2], -1);
                @(posedge clk) cnt <= 16'h0000;
            end
        join
        @(posedge clk) cnt <= 16'h2468;
        checkFlags();
        checkIrq();
        rd(OCF_OFF_COUNT);
        check(d, 32'h2468);
        // Count equals the new value only in the cycle after the high-byte write: must not match
        nv = cmpM[0] ^ 16'h4000;
        fork
            wr(OCF_OFF_CMP_BASE, {16'h0, nv});
            begin
                repeat (3) @(posedge clk);
                cnt <= nv;
                model(nv, 0);
                @(posedge clk) cnt <= 16'h0000;
            end
        join
        cmpM[0] = nv;
        checkFlags();
        pulse(nv);
        checkFlags();
        wr(OCF_OFF_COUNT, 32'h0);
        check({30'h0, r}, {30'h0, OCF_RESP_OKAY});
        wr(8'h40, 32'h1f);
        check({30'h0, r}, {30'h0, OCF_RESP_SLVERR});
        rd(8'h40);
        check({30'h0, r}, {30'h0, OCF_RESP_SLVERR});
        // One-shot use: software drops the enable once the request has been seen
        enM = '0;
        wr(OCF_OFF_IRQEN, 32'h0);
        checkIrq();
        checkFlags();
        conclude();
    end
endmodule
`default_nettype wire
